/* hdl/synth_vco_ref_config_regs.v */
/*
 configuration register bank for the synthesizer vco and reference
 path, reached over avalon-mm with waitrequest, 32-bit data words.
 word map, byte address four times the word index:
  0x08 vco_override_control: current and band override bits
  0x09 reference_doubler_control: reference input doubler
  0x0a fixed_word_a: host-programmed fixed word
  0x0b post_ref_divider: post divider in bits 11-4
  0x0c pre_ref_divider: pre divider in bits 7-0
  0x0d fixed_word_b: host-programmed fixed word
  0x0e pump_gain_control: pump gain code in bits 6-4
  0x0f fixed_word_c: host-programmed fixed word
  0x10 vco_current_setting: programmed vco current in bits 8-0
 assumes a single clock, calibration results from the same domain
 and a master that holds its request until waitrequest is low.
*/
// Added by the designer: register access over Avalon-MM.
// Notes on behaviour
// R1 - current override bit selects programmed vco current
// R2 - band override bit selects programmed capacitor band
// R3 - host writes fixed fields of override word
// R4 - doubler bit enables reference input doubler
// R5 - host writes fixed fields of doubler word
// R6 - host programs fixed word a with 0x10d8
// R7 - post divider field bits 11-4, resets to 1
// R8 - pre divider field bits 7-0, resets to 1
// R9 - host writes pre divider upper byte 0x50
// R10 - host programs fixed word b with 0x4000
// R11 - pump gain code selects summed pump current
// R12 - host writes fixed fields of pump word
// R13 - host programs fixed word c with 0x64f
// R14 - current setting applies only during current override
// R15 - host keeps band value within 0 to 183
// R16 - 16-bit registers, reset values, hold until rewritten
`timescale 1ns/1ps
`include "synth_cfg_regs.vh"

module synth_vco_ref_config_regs (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // avalon-mm slave
    input wire [6:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // calibration results from the vco calibration engine
    input wire [8:0] cal_current_value,
    input wire [7:0] cal_band_value,
    // band value, held outside this window, from its own register
    input wire [7:0] vco_band_value,
    // control outputs to the synthesizer core
    output reg [8:0] vco_current_out,
    output reg [7:0] vco_band_out,
    output reg ref_doubler_en,
    output reg [7:0] post_ref_div,
    output reg [7:0] pre_ref_div,
    output reg [4:0] pump_current_sel,
    output reg pump_tristate,
    output reg pump_code_unused
);

    // register storage
    reg [15:0] vco_override_control_reg;
    reg [15:0] reference_doubler_control_reg;
    reg [15:0] fixed_word_a_reg;
    reg [15:0] post_ref_divider_reg;
    reg [15:0] pre_ref_divider_reg;
    reg [15:0] fixed_word_b_reg;
    reg [15:0] pump_gain_control_reg;
    reg [15:0] fixed_word_c_reg;
    reg [15:0] vco_current_setting_reg;

    // bus handshake state
    localparam ST_IDLE = 1'b0;
    localparam ST_DONE = 1'b1;
    reg state_reg;
    reg state_next;

    wire [4:0] word_index;
    wire in_range;
    wire [4:0] pump_sel_w;
    wire pump_tri_w;
    wire pump_unused_w;
    wire vco_current_override_en;
    wire vco_band_override_en;
    wire [8:0] vco_current_value;
    reg [15:0] read_word;

    // accepted write and its per-word strobes
    wire write_accept;
    wire [15:0] wr_half;
    wire [1:0] wr_lanes;
    wire hit_override;
    wire hit_doubler;
    wire hit_fixed_a;
    wire hit_post_div;
    wire hit_pre_div;
    wire hit_fixed_b;
    wire hit_pump;
    wire hit_fixed_c;
    wire hit_current;

    // merge byte lanes of the low half word into a register value
    function [15:0] merge_lanes;
        input [15:0] old_value;
        input [15:0] new_value;
        input [1:0] lanes;
        begin
            merge_lanes[7:0] = lanes[0] ? new_value[7:0] : old_value[7:0];
            merge_lanes[15:8] = lanes[1] ? new_value[15:8] :
                old_value[15:8];
        end
    endfunction

    // byte address to word index; low two address bits ignored
    assign word_index = avs_address[6:2];
    assign in_range = (word_index >= `IDX_FIRST) &&
        (word_index <= `IDX_VCO_CURRENT_SETTING);

    // write strobes; a write lands on the edge that sees waitrequest low
    assign write_accept = (state_reg == ST_DONE) && avs_write && in_range;
    assign wr_half = avs_writedata[15:0];
    assign wr_lanes = avs_byteenable[1:0];
    assign hit_override = write_accept &&
        (word_index == `IDX_VCO_OVERRIDE_CONTROL);
    assign hit_doubler = write_accept &&
        (word_index == `IDX_REFERENCE_DOUBLER_CONTROL);
    assign hit_fixed_a = write_accept &&
        (word_index == `IDX_FIXED_WORD_A);
    assign hit_post_div = write_accept &&
        (word_index == `IDX_POST_REF_DIVIDER);
    assign hit_pre_div = write_accept &&
        (word_index == `IDX_PRE_REF_DIVIDER);
    assign hit_fixed_b = write_accept &&
        (word_index == `IDX_FIXED_WORD_B);
    assign hit_pump = write_accept &&
        (word_index == `IDX_PUMP_GAIN_CONTROL);
    assign hit_fixed_c = write_accept &&
        (word_index == `IDX_FIXED_WORD_C);
    assign hit_current = write_accept &&
        (word_index == `IDX_VCO_CURRENT_SETTING);

    assign vco_current_override_en =
        vco_override_control_reg[`BIT_CURRENT_OVERRIDE];
    assign vco_band_override_en =
        vco_override_control_reg[`BIT_BAND_OVERRIDE];
    assign vco_current_value =
        vco_current_setting_reg[`CURRENT_HI:`CURRENT_LO];

    // waitrequest drops one cycle after a request, then re-arms
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (avs_read || avs_write) begin
                    state_next = ST_DONE;
                end
            end
            ST_DONE: state_next = ST_IDLE;
            default: state_next = ST_IDLE;
        endcase
    end

    // read mux; unmapped words read as zero
    always @* begin
        read_word = 16'h0000;
        case (word_index)
            `IDX_VCO_OVERRIDE_CONTROL: read_word = vco_override_control_reg;
            `IDX_REFERENCE_DOUBLER_CONTROL:
                read_word = reference_doubler_control_reg;
            `IDX_FIXED_WORD_A: read_word = fixed_word_a_reg;
            `IDX_POST_REF_DIVIDER: read_word = post_ref_divider_reg;
            `IDX_PRE_REF_DIVIDER: read_word = pre_ref_divider_reg;
            `IDX_FIXED_WORD_B: read_word = fixed_word_b_reg;
            `IDX_PUMP_GAIN_CONTROL: read_word = pump_gain_control_reg;
            `IDX_FIXED_WORD_C: read_word = fixed_word_c_reg;
            `IDX_VCO_CURRENT_SETTING: read_word = vco_current_setting_reg;
            default: read_word = 16'h0000;
        endcase
    end

    // handshake state; waitrequest low for one cycle per access
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            avs_waitrequest <= 1'b1;
        end else begin
            state_reg <= state_next;
            avs_waitrequest <= ~((state_reg == ST_IDLE) &&
                (avs_read || avs_write));
        end
    end

    // read data taken on the request edge, held until the next read
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h00000000;
        end else if ((state_reg == ST_IDLE) && avs_read) begin
            avs_readdata <= {16'h0000, read_word};
        end
    end

    // override word: current and band override bits
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vco_override_control_reg <= `RST_VCO_OVERRIDE_CONTROL; // R16
        end else if (hit_override) begin
            vco_override_control_reg <= merge_lanes(
                vco_override_control_reg, wr_half, wr_lanes); // R16
        end
    end

    // doubler word: reference input doubler enable
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            reference_doubler_control_reg <=
                `RST_REFERENCE_DOUBLER_CONTROL; // R16
        end else if (hit_doubler) begin
            reference_doubler_control_reg <= merge_lanes(
                reference_doubler_control_reg, wr_half, wr_lanes); // R16
        end
    end

    // fixed word a: stored as written, host value not checked
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fixed_word_a_reg <= `RST_FIXED_WORD_A; // R16
        end else if (hit_fixed_a) begin
            fixed_word_a_reg <= merge_lanes(
                fixed_word_a_reg, wr_half, wr_lanes); // R16
        end
    end

    // post divider word
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            post_ref_divider_reg <= `RST_POST_REF_DIVIDER; // R16
        end else if (hit_post_div) begin
            post_ref_divider_reg <= merge_lanes(
                post_ref_divider_reg, wr_half, wr_lanes); // R16
        end
    end

    // pre divider word
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pre_ref_divider_reg <= `RST_PRE_REF_DIVIDER; // R16
        end else if (hit_pre_div) begin
            pre_ref_divider_reg <= merge_lanes(
                pre_ref_divider_reg, wr_half, wr_lanes); // R16
        end
    end

    // fixed word b: stored as written
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fixed_word_b_reg <= `RST_FIXED_WORD_B; // R16
        end else if (hit_fixed_b) begin
            fixed_word_b_reg <= merge_lanes(
                fixed_word_b_reg, wr_half, wr_lanes); // R16
        end
    end

    // pump word: gain code feeds the decoder
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pump_gain_control_reg <= `RST_PUMP_GAIN_CONTROL; // R16
        end else if (hit_pump) begin
            pump_gain_control_reg <= merge_lanes(
                pump_gain_control_reg, wr_half, wr_lanes); // R16
        end
    end

    // fixed word c: stored as written
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fixed_word_c_reg <= `RST_FIXED_WORD_C; // R16
        end else if (hit_fixed_c) begin
            fixed_word_c_reg <= merge_lanes(
                fixed_word_c_reg, wr_half, wr_lanes); // R16
        end
    end

    // current setting word: used only under current override
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vco_current_setting_reg <= `RST_VCO_CURRENT_SETTING; // R16
        end else if (hit_current) begin
            vco_current_setting_reg <= merge_lanes(
                vco_current_setting_reg, wr_half, wr_lanes); // R16
        end
    end

    // pump code decoder
    pump_gain_decode u_pump_decode (
        .code(pump_gain_control_reg[`PUMP_HI:`PUMP_LO]),
        .current_sel(pump_sel_w),
        .tristate(pump_tri_w),
        .code_unused(pump_unused_w)
    );

    // vco current and band source selection
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            vco_current_out <= 9'h000;
            vco_band_out <= 8'h00;
        end else begin
            // override chooses programmed current over calibration
            vco_current_out <= vco_current_override_en ?
                vco_current_value : cal_current_value; // R1 R14
            // override chooses programmed band over calibration
            vco_band_out <= vco_band_override_en ?
                vco_band_value : cal_band_value; // R2
        end
    end

    // reference path: doubler and both dividers
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ref_doubler_en <= 1'b0;
            post_ref_div <= 8'h01;
            pre_ref_div <= 8'h01;
        end else begin
            ref_doubler_en <=
                reference_doubler_control_reg[`BIT_REF_DOUBLER]; // R4
            post_ref_div <=
                post_ref_divider_reg[`POST_DIV_HI:`POST_DIV_LO]; // R7
            pre_ref_div <=
                pre_ref_divider_reg[`PRE_DIV_HI:`PRE_DIV_LO]; // R8
        end
    end

    // pump gain outputs; unused codes already forced to tri-state
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pump_current_sel <= 5'h10;
            pump_tristate <= 1'b0;
            pump_code_unused <= 1'b0;
        end else begin
            pump_current_sel <= pump_sel_w; // R11
            pump_tristate <= pump_tri_w; // R11
            pump_code_unused <= pump_unused_w; // R11
        end
    end

endmodule // synth_vco_ref_config_regs

/* hdl/synth_cfg_regs.vh */
/*
 constants for the synthesizer configuration register bank:
 register indices, field positions, reset values and pump codes.
 assumes inclusion by bare name from the design files.
*/
`ifndef SYNTH_CFG_REGS_VH
`define SYNTH_CFG_REGS_VH

// register indices; byte address is four times the index
`define IDX_VCO_OVERRIDE_CONTROL 5'h08
`define IDX_REFERENCE_DOUBLER_CONTROL 5'h09
`define IDX_FIXED_WORD_A 5'h0a
`define IDX_POST_REF_DIVIDER 5'h0b
`define IDX_PRE_REF_DIVIDER 5'h0c
`define IDX_FIXED_WORD_B 5'h0d
`define IDX_PUMP_GAIN_CONTROL 5'h0e
`define IDX_FIXED_WORD_C 5'h0f
`define IDX_VCO_CURRENT_SETTING 5'h10
`define IDX_FIRST 5'h08
`define NUM_REGS 9

// reset values
`define RST_VCO_OVERRIDE_CONTROL 16'h2000
`define RST_REFERENCE_DOUBLER_CONTROL 16'h0604
`define RST_FIXED_WORD_A 16'h10f8
`define RST_POST_REF_DIVIDER 16'h0018
`define RST_PRE_REF_DIVIDER 16'h5001
`define RST_FIXED_WORD_B 16'h4000
`define RST_PUMP_GAIN_CONTROL 16'h1e70
`define RST_FIXED_WORD_C 16'h064f
`define RST_VCO_CURRENT_SETTING 16'h0080

// field positions
`define BIT_CURRENT_OVERRIDE 14
`define BIT_BAND_OVERRIDE 11
`define BIT_REF_DOUBLER 12
`define POST_DIV_HI 11
`define POST_DIV_LO 4
`define PRE_DIV_HI 7
`define PRE_DIV_LO 0
`define PUMP_HI 6
`define PUMP_LO 4
`define CURRENT_HI 8
`define CURRENT_LO 0

// pump gain codes, summed up and down current
`define PUMP_TRISTATE 3'h0
`define PUMP_3MA 3'h4
`define PUMP_6MA 3'h1
`define PUMP_9MA 3'h5
`define PUMP_12MA 3'h3
`define PUMP_15MA 3'h7

// bus answer latency in cycles after a request is seen
`define BUS_WAIT_CYCLES 1

`endif

/* hdl/pump_gain_decode.v */
/*
 decodes the charge pump gain code into a one-hot current selection
 and a tri-state flag; unused codes are flagged and force tri-state.
 assumes a registered code from the same clock domain.
*/
`timescale 1ns/1ps
`include "synth_cfg_regs.vh"

module pump_gain_decode (
    // code in
    input wire [2:0] code,
    // decoded outputs: bit0 3 mA ... bit4 15 mA
    output reg [4:0] current_sel,
    output reg tristate,
    output reg code_unused
);

    // map each legal code to its current step
    always @* begin
        current_sel = 5'h00;
        tristate = 1'b0;
        code_unused = 1'b0;
        case (code)
            `PUMP_TRISTATE: tristate = 1'b1; // R11
            `PUMP_3MA: current_sel = 5'h01; // R11
            `PUMP_6MA: current_sel = 5'h02; // R11
            `PUMP_9MA: current_sel = 5'h04; // R11
            `PUMP_12MA: current_sel = 5'h08; // R11
            `PUMP_15MA: current_sel = 5'h10; // R11
            default: begin
                tristate = 1'b1;
                code_unused = 1'b1;
            end
        endcase
    end

endmodule // pump_gain_decode

/* verif/cfg_regs_asserts.sv */
/* bus and output checks for the vco and reference register bank.
 assumes a bind to the bank top and a single clock domain. */
`timescale 1ns/1ps
module cfg_regs_asserts (
    // clock and reset
    input wire clk_sys,
    input wire rst,
    // bus
    input wire [6:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    // core side
    input wire [8:0] cal_current_value,
    input wire [7:0] cal_band_value,
    input wire [7:0] vco_band_value,
    input wire [8:0] vco_current_out,
    input wire [7:0] vco_band_out,
    input wire ref_doubler_en,
    input wire [7:0] post_ref_div,
    input wire [7:0] pre_ref_div,
    input wire [4:0] pump_current_sel,
    input wire pump_tristate,
    input wire pump_code_unused
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    // word index and an accepted write of the whole low half
    wire [4:0] idx = avs_address[6:2];
    wire wacc = avs_write && !avs_waitrequest && (&avs_byteenable[1:0]);
    // expected unused, tri-state and one-hot flags for a pump code
    function automatic [6:0] pump_exp(input [2:0] c);
        case (c)
            3'h0: pump_exp = 7'h20;
            3'h4: pump_exp = 7'h01;
            3'h1: pump_exp = 7'h02;
            3'h5: pump_exp = 7'h04;
            3'h3: pump_exp = 7'h08;
            3'h7: pump_exp = 7'h10;
            default: pump_exp = 7'h60;
        endcase
    endfunction
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_answer_soon: assert property ((avs_read || avs_write)
        && avs_waitrequest |-> ##[1:3] !avs_waitrequest)
        else $error("request not answered in time");
    a_unmapped_zero: assert property (avs_read && !avs_waitrequest
        && (idx < 5'h08 || idx > 5'h10) |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_doubler_follow: assert property (wacc && idx == 5'h09
        |=> ##1 ref_doubler_en == $past(avs_writedata[12], 2))
        else $error("doubler enable wrong");
    a_post_follow: assert property (wacc && idx == 5'h0b
        |=> ##1 post_ref_div == $past(avs_writedata[11:4], 2))
        else $error("post divider wrong");
    a_pre_follow: assert property (wacc && idx == 5'h0c
        |=> ##1 pre_ref_div == $past(avs_writedata[7:0], 2))
        else $error("pre divider wrong");
    a_pump_follow: assert property (wacc && idx == 5'h0e
        |=> ##1 {pump_code_unused, pump_tristate, pump_current_sel}
        == pump_exp($past(avs_writedata[6:4], 2)))
        else $error("pump decode wrong");
    a_current_cal: assert property (wacc && idx == 5'h08
        && !avs_writedata[14]
        |=> ##1 vco_current_out == $past(cal_current_value))
        else $error("current not from calibration");
    a_band_select: assert property (wacc && idx == 5'h08
        |=> ##1 vco_band_out == ($past(avs_writedata[11], 2)
        ? $past(vco_band_value) : $past(cal_band_value)))
        else $error("band source wrong");
    c_write: cover property (wacc);
    c_read: cover property (avs_read && !avs_waitrequest);
    c_override: cover property (wacc && idx == 5'h08 && avs_writedata[14]);
endmodule // cfg_regs_asserts

bind synth_vco_ref_config_regs cfg_regs_asserts i_cfg_regs_asserts (
    .clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .cal_current_value,
    .cal_band_value, .vco_band_value, .vco_current_out, .vco_band_out,
    .ref_doubler_en, .post_ref_div, .pre_ref_div, .pump_current_sel,
    .pump_tristate, .pump_code_unused);

/* verif/host_model.sv */
/* host controller model: avalon master that programs the bank.
 assumes a top module named testbench that owns end_sim. */
`timescale 1ns/1ps
module host_model (
    // clock
    input wire clk_sys,
    // avalon master
    output reg [6:0] avs_address,
    output reg avs_read,
    output reg avs_write,
    output reg [31:0] avs_writedata,
    output reg [3:0] avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest
);
    reg [15:0] rdat;
    integer slow = 1;
    reg [3:0] lanes = 4'hf;
    // idle bus at time zero
    initial begin
        avs_address = 7'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
    end
    // one access, held until waitrequest is sampled low
    task automatic acc(input rw, input [4:0] i, input [15:0] d);
        integer n;
        begin
            n = 0;
            repeat (slow) @(posedge clk_sys);
            avs_address <= {i, 2'b00};
            avs_writedata <= {16'h0000, d};
            avs_byteenable <= lanes;
            avs_read <= !rw;
            avs_write <= rw;
            @(posedge clk_sys);
            while (avs_waitrequest !== 1'b0) begin
                n = n + 1;
                if (n > 20) begin
                    testbench.n_errors = testbench.n_errors + 1;
                    testbench.end_sim;
                end
                @(posedge clk_sys);
            end
            rdat = avs_readdata[15:0];
            avs_read <= 1'b0;
            avs_write <= 1'b0;
            // released lines must not keep their last value
            avs_address <= ~avs_address;
            avs_writedata <= ~avs_writedata;
        end
    endtask
    // the values a host must place in every word
    task automatic program_fixed;
        begin
            acc(1'b1, 5'h08, 16'h2000);
            acc(1'b1, 5'h09, 16'h0604);
            acc(1'b1, 5'h0a, 16'h10d8);
            acc(1'b1, 5'h0b, 16'h0018);
            acc(1'b1, 5'h0c, 16'h5001);
            acc(1'b1, 5'h0d, 16'h4000);
            acc(1'b1, 5'h0e, 16'h1e70);
            acc(1'b1, 5'h0f, 16'h064f);
            acc(1'b1, 5'h10, 16'h0080);
        end
    endtask
endmodule // host_model

/* verif/testbench.sv */
/* self-checking bench for the vco and reference register bank.
 assumes the host model drives the bus and the checker is bound. */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests = n_tests + 1; if ((g) !== (e)) begin \
    n_errors = n_errors + 1; \
    $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module testbench;
    // clock, reset and core-side stimulus
    reg clk_sys = 1'b0;
    reg rst = 1'b1;
    reg [8:0] cal_current_value = 9'h0a5;
    reg [7:0] cal_band_value = 8'h3c;
    reg [7:0] vco_band_value = 8'hb7;
    wire [6:0] avs_address;
    wire avs_read, avs_write, avs_waitrequest, ref_doubler_en;
    wire [31:0] avs_writedata, avs_readdata;
    wire [3:0] avs_byteenable;
    wire [8:0] vco_current_out;
    wire [7:0] vco_band_out, post_ref_div, pre_ref_div;
    wire [4:0] pump_current_sel;
    wire pump_tristate, pump_code_unused;
    wire [6:0] pump_obs = {pump_code_unused, pump_tristate, pump_current_sel};
    integer n_errors = 0;
    integer n_tests = 0;
    integer k;
    reg [15:0] rst_vals [0:8] = '{16'h2000, 16'h0604, 16'h10f8, 16'h0018,
        16'h5001, 16'h4000, 16'h1e70, 16'h064f, 16'h0080};
    reg [15:0] prog_vals [0:8] = '{16'h2000, 16'h0604, 16'h10d8, 16'h0018,
        16'h5001, 16'h4000, 16'h1e70, 16'h064f, 16'h0080};
    reg [6:0] pump_vals [0:7] = '{7'h20, 7'h02, 7'h60, 7'h08, 7'h01,
        7'h04, 7'h60, 7'h10};
    always #12.5 clk_sys = ~clk_sys;
    synth_vco_ref_config_regs i_synth_vco_ref_config_regs (.clk_sys, .rst,
        .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .cal_current_value, .cal_band_value,
        .vco_band_value, .vco_current_out, .vco_band_out, .ref_doubler_en,
        .post_ref_div, .pre_ref_div, .pump_current_sel, .pump_tristate,
        .pump_code_unused);
    host_model i_host_model (.clk_sys, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest);
    // verdict and end of run
    task end_sim;
        begin
            $display("tests %0d errors %0d", n_tests, n_errors);
            if (n_errors == 0 && n_tests > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    // bus helpers; outputs follow a write one edge after its answer
    task wr(input [4:0] i, input [15:0] d);
        i_host_model.acc(1'b1, i, d);
    endtask
    task rd_chk(input [4:0] i, input [15:0] e);
        begin
            i_host_model.acc(1'b0, i, 16'h0000);
            `CHK(i_host_model.rdat, e)
        end
    endtask
    task settle;
        repeat (2) @(posedge clk_sys);
    endtask
    // reset state of outputs and words, then the host programming
    task t_reset_and_fixed;
        begin
            `CHK({ref_doubler_en, post_ref_div, pre_ref_div}, 17'h00101)
            for (k = 0; k < 9; k = k + 1)
                rd_chk(5'h08 + k[4:0], rst_vals[k]);
            i_host_model.program_fixed;
            for (k = 0; k < 9; k = k + 1)
                rd_chk(5'h08 + k[4:0], prog_vals[k]);
        end
    endtask
    // doubler, divider bounds and a low-lane-only write
    task t_fields;
        begin
            wr(5'h09, 16'h1604);
            wr(5'h0b, 16'h0ff8);
            wr(5'h0c, 16'h50ff);
            settle;
            `CHK({ref_doubler_en, post_ref_div, pre_ref_div}, 17'h1ffff)
            i_host_model.lanes = 4'h1;
            wr(5'h0b, 16'h1234);
            i_host_model.lanes = 4'hf;
            wr(5'h0c, 16'h5000);
            wr(5'h09, 16'h0604);
            settle;
            `CHK({ref_doubler_en, post_ref_div, pre_ref_div}, 17'h0f300)
            rd_chk(5'h0b, 16'h0f34);
        end
    endtask
    // every pump gain code, used and unused
    task t_pump;
        for (k = 0; k < 8; k = k + 1) begin
            wr(5'h0e, {9'h03c, k[2:0], 4'h0});
            settle;
            `CHK(pump_obs, pump_vals[k])
        end
    endtask
    // override bits pick programmed or calibrated values
    task t_override;
        begin
            wr(5'h10, 16'h01ab);
            wr(5'h08, 16'h6000);
            settle;
            `CHK({vco_current_out, vco_band_out}, 17'h1ab3c)
            wr(5'h08, 16'h2800);
            cal_current_value <= 9'h15a;
            settle;
            `CHK({vco_current_out, vco_band_out}, 17'h15ab7)
            wr(5'h10, 16'h0001);
            settle;
            `CHK(vco_current_out, 9'h15a)
        end
    endtask
    // unmapped words with a slow host
    task t_unmapped;
        begin
            i_host_model.slow = 3;
            wr(5'h11, 16'hffff);
            rd_chk(5'h11, 16'h0000);
            rd_chk(5'h07, 16'h0000);
            rd_chk(5'h08, 16'h2800);
        end
    endtask
    // reset in mid-run brings the words back to their reset values
    task t_reset_again;
        begin
            rst <= 1'b1;
            settle;
            rst <= 1'b0;
            @(posedge clk_sys);
            rd_chk(5'h08, 16'h2000);
            rd_chk(5'h0a, 16'h10f8);
        end
    endtask
    // main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_reset_and_fixed;
        t_fields;
        t_pump;
        t_override;
        t_unmapped;
        t_reset_again;
        end_sim;
    end
endmodule // testbench
